//--- logic/level_sync.sv
// three-flop synchroniser; a change counts once the last two flops agree
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module level_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic s1, s2, s3;
    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                sync_out <= s3;
            end
        end
    end
endmodule // level_sync
`default_nettype wire

//--- logic/temp_serial_pkg.sv
// constants for the temperature sensor serial slave port
// assumes a 40 MHz system clock and a master-driven serial clock
// Functional notes
// - device takes part in a transfer only while chip select is low.
// - with chip select high, serial clock edges are ignored entirely.
// - data input sampled on each rising serial clock edge, shifted toward control.
// - result bits presented on data output, changing on each falling edge.
// - chip select high releases data output to high impedance.
// - 16 pulses: leading zero, 13 result bits msb first, last bit held.
// - control loaded on fifteenth falling edge; third bit one enters shutdown.
// - result is 13-bit two's complement, sign on top, sixteenth degree.
// - conversion every second, 208 us long, timer restarts after access.
package temp_serial_pkg;
    localparam int RESULT_W = 13;
    localparam int SIGN_POS = 12;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] LOAD_EDGE = 5'h0f;
    localparam int SHUTDOWN_POS = 12;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 13'h0000;
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int PERIOD_MS = 1000;
    localparam int CONV_US = 208;
    localparam int PERIOD_CYCLES = PERIOD_MS * (SYS_CLK_HZ / 1000);
    localparam int CONV_CYCLES = CONV_US * (SYS_CLK_HZ / 1_000_000);
    localparam int TIMER_W = 26;
endpackage

//--- logic/temp_serial_port.sv
// serial slave port and conversion scheduler of the temperature sensor
// assumes sclk comes from the master and idles during deselect; cs_n is async
// link logic runs on sclk and, apart from the control register, is cleared by deselect; everything else runs on sys_clk
// and sees the link through synchronisers, through quasi-static words and, for the snapshot load, through the raw cs_n pin
`timescale 1ns/1ps
`default_nettype none
module temp_serial_port #(
    parameter int PERIOD_CYCLES = temp_serial_pkg::PERIOD_CYCLES,
    parameter int CONV_CYCLES = temp_serial_pkg::CONV_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    input wire logic [temp_serial_pkg::RESULT_W-1:0] adc_sample,
    output logic adc_start,
    output logic shutdown,
    output logic [temp_serial_pkg::RESULT_W-1:0] temp_result
);
    typedef enum {ST_IDLE, ST_CONVERT} conv_state_t;

    // frame as seen on the pins, for a master whose clock idles low:
    //   select      dout driven, leading zero shown before any clock
    //   rise k      din sampled into the shift register
    //   fall 1..13  result bits go out, sign first
    //   fall 14..16 the last bit is held
    //   fall 15     the control word is committed if select is still low
    //   deselect    dout released, link counters cleared
    // the link counters need no system reset: deselect clears them, and the pin is high
    // whenever no master is talking to the part
    // limitation: a master that leaves select low for more than one frame gets the held
    // last bit, not a second reading; each reading needs its own select pulse
    // the result is snapshotted while deselected so that a conversion finishing
    // during a frame cannot tear the word being shifted out

    // link domain: async chip select clears the frame; only the control register takes the system reset
    logic [4:0] rise_cnt;
    logic [4:0] fall_cnt;
    logic [15:0] in_shift;
    logic [temp_serial_pkg::RESULT_W-1:0] snap;
    logic out_bit;
    logic ctl_pd;
    logic ctl_toggle;
    logic frame_open;

    wire selected = ~cs_n;
    wire [15:0] next_in_shift = {in_shift[14:0], din};

    // rising edges sample input; cs_n high holds everything cleared
    // the rise count saturates, so an overlong frame never lines up a second load
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rise_cnt <= 5'h00;
            in_shift <= 16'h0000;
        end else begin
            in_shift <= next_in_shift;
            if (rise_cnt != 5'h1f) begin
                rise_cnt <= rise_cnt + 5'h01;
            end
        end
    end

    // the shutdown bit is the third bit of the frame; at edge 15 it sits at bit 12;
    // both counts must agree, so a runt clock pulse cannot load a misaligned word
    wire fall_at_load = (fall_cnt == temp_serial_pkg::LOAD_EDGE - 5'h01);
    wire rise_at_load = (rise_cnt == temp_serial_pkg::LOAD_EDGE);
    wire load_now = fall_at_load && rise_at_load;
    wire [4:0] next_fall = (fall_cnt == 5'h1f) ? fall_cnt : fall_cnt + 5'h01;
    wire out_step = fall_cnt < 5'(temp_serial_pkg::RESULT_W);

    // falling edges move the output; the snapshot is read from the first one on, and loaded only while deselected
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            fall_cnt <= 5'h00;
            out_bit <= 1'b0;
        end else begin
            fall_cnt <= next_fall;
            if (out_step) begin
                out_bit <= snap[temp_serial_pkg::RESULT_W-1 - 32'(fall_cnt)];
            end
        end
    end

    // control register survives deselect; loaded only on fifteenth fall
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            ctl_pd <= 1'b0;
            ctl_toggle <= 1'b0;
        end else if (!cs_n && load_now) begin
            ctl_pd <= in_shift[temp_serial_pkg::SHUTDOWN_POS];
            ctl_toggle <= ~ctl_toggle;
        end
    end

    // leading zero stands before the first falling edge
    assign dout = (fall_cnt == 5'h00) ? 1'b0 : out_bit;
    assign dout_oe = selected;

    // system domain
    logic cs_sync_n;
    logic ctl_sync;
    logic ctl_seen;
    logic cs_prev_n;
    logic [temp_serial_pkg::TIMER_W-1:0] timer;
    conv_state_t state;
    conv_state_t next_state;
    logic [temp_serial_pkg::TIMER_W-1:0] next_timer;
    logic [temp_serial_pkg::RESULT_W-1:0] next_result;
    // one access end may be waiting for the engine while a conversion finishes
    logic restart_pend;
    logic next_restart_pend;

    level_sync u_cs_sync (
        .clk(sys_clk),
        .rst(rst),
        .async_in(~cs_n),
        .sync_out(frame_open)
    );
    level_sync u_ctl_sync (
        .clk(sys_clk),
        .rst(rst),
        .async_in(ctl_toggle),
        .sync_out(ctl_sync)
    );
    assign cs_sync_n = ~frame_open;

    // crossing back into the system clock: chip select and the control toggle each pass
    // their own synchroniser; the control bit itself is only read once the toggle has
    // settled, and it cannot move again before the next fifteenth falling edge
    wire access_end = cs_sync_n && !cs_prev_n;
    wire ctl_event = ctl_sync != ctl_seen;
    // the new control value gates the start pulse in the cycle it arrives; the state machine still
    // reads the registered shutdown, so on a wake in that cycle the pulse goes out but idle is kept
    wire shutdown_eff = ctl_event ? ctl_pd : shutdown;
    wire period_due = timer >= temp_serial_pkg::TIMER_W'(PERIOD_CYCLES - 1);
    wire conv_done = timer >= temp_serial_pkg::TIMER_W'(CONV_CYCLES - 1);
    wire restart = access_end || restart_pend;
    wire engine_free = (state == ST_IDLE) && !shutdown_eff;
    wire snap_load = !frame_open && cs_n;

    // an access that ends while a conversion is still running is parked, not lost
    assign next_restart_pend = (access_end && (state != ST_IDLE)) || (restart_pend && !adc_start);

    // the snapshot register lives in the system domain but only changes while the raw
    // pin and its synchronised copy both say deselected; the raw pin closes the window
    // before the synchroniser could, so the link logic always shifts a settled word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            snap <= temp_serial_pkg::RESULT_RESET;
        end else if (snap_load) begin
            snap <= temp_result;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cs_prev_n <= 1'b1;
            ctl_seen <= 1'b0;
            shutdown <= 1'b0;
            restart_pend <= 1'b0;
        end else begin
            cs_prev_n <= cs_sync_n;
            ctl_seen <= ctl_sync;
            restart_pend <= next_restart_pend;
            if (ctl_event) begin
                shutdown <= ctl_pd;
            end
        end
    end

    // a start pulse lasts one cycle: the state leaves idle on the same edge unless the registered shutdown is still set
    assign adc_start = engine_free && (restart || period_due);

    // one timer counts both conversion time and the period; shutdown parks it at zero,
    // so no period can fall due until the part is woken again
    always_comb begin
        next_state = state;
        next_timer = timer + 1'b1;
        next_result = temp_result;
        case (state)
            ST_IDLE: begin
                if (shutdown) begin
                    next_timer = '0;
                end else if (adc_start) begin
                    next_state = ST_CONVERT;
                    next_timer = '0;
                end
            end
            ST_CONVERT: begin
                if (conv_done) begin
                    next_result = adc_sample;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_timer = '0;
            end
        endcase
    end

    // registers only; every decision sits in the process above
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            timer <= '0;
            temp_result <= temp_serial_pkg::RESULT_RESET;
        end else begin
            state <= next_state;
            timer <= next_timer;
            temp_result <= next_result;
        end
    end
endmodule // temp_serial_port
`default_nettype wire

//--- sim/port_properties.sv
// pin-level assertions for the serial port
// bound into temp_serial_port; sclk edges are not sampled here
`timescale 1ns/1ps
`default_nettype none
module port_props #(parameter int PERIOD_CYCLES = 200) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic [12:0] adc_sample,
    input wire logic adc_start,
    input wire logic shutdown,
    input wire logic [12:0] temp_result
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    int idle;
    // any access restarts the timer, so a frame clears the count too
    always_ff @(posedge sys_clk) idle <= (rst | adc_start | shutdown | !cs_n) ? 0 : idle + 1;
    sequence quiet; !adc_start[*8]; endsequence
    oe_sel_a: assert property (dout_oe == !cs_n) else $error("oe");
    lead_zero_a: assert property ($fell(cs_n) |-> !dout) else $error("lead");
    reset_val_a: assert property (disable iff (0) rst |=> !shutdown && !temp_result)
        else $error("reset");
    result_src_a: assert property ($changed(temp_result) |->
        temp_result == $past(adc_sample)) else $error("source");
    shut_quiet_a: assert property ($rose(shutdown) |=> quiet) else $error("conv");
    ctrl_hold_a: assert property ($changed(shutdown) |-> cs_n) else $error("ctrl");
    period_max_a: assert property (idle <= PERIOD_CYCLES + 8) else $error("period");
    access_restart_a: assert property ($rose(cs_n) |-> ##[1:8] (adc_start | shutdown))
        else $error("restart");
endmodule // port_props
bind temp_serial_port port_props #(.PERIOD_CYCLES(PERIOD_CYCLES)) props (.sys_clk, .rst, .cs_n,
    .dout, .dout_oe, .adc_sample, .adc_start, .shutdown, .temp_result);
`default_nettype wire

//--- sim/serial_master.sv
// serial master model; its clock runs only inside frames
// sclk idles low, dout is read on each rise
`timescale 1ns/1ps
`default_nettype none
module serial_master (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    initial {sclk, cs_n, din} = 3'b010;
    // sel low clocks the wire with the device left deselected
    task automatic frame(int n, logic [15:0] tx, logic sel, output logic [15:0] rx);
        cs_n = !sel;
        #30;
        for (int i = 0; i < n; i++) begin
            din = tx[15-i];
            #6 sclk = 1'b1;
            rx[15-i] = dout;
            #6 sclk = 1'b0;
        end
        #10 cs_n = 1'b1;
        din = !din; // released line shows the inverse of its last bit
    endtask
endmodule // serial_master
`default_nettype wire

//--- sim/testbench.sv
// bench for temp_serial_port driven by the master model
// short timer counts; a row is a result and the frame it reads as
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0, rst = 1'b1;
    logic [12:0] adc_sample = 13'h0000;
    wire logic sclk, cs_n, din, dout, dout_oe, adc_start, shutdown;
    wire logic [12:0] temp_result;
    logic [15:0] rx;
    int errors = 0, checks = 0, cycles = 0;
    logic [28:0] rows [3] = '{{13'h1c90, 16'h7240}, {13'h1fff, 16'h7fff}, {13'h0960, 16'h2580}};
    temp_serial_port #(.PERIOD_CYCLES(200), .CONV_CYCLES(20)) dut (.sys_clk, .rst, .sclk, .cs_n,
        .din, .dout, .dout_oe, .adc_sample, .adc_start, .shutdown, .temp_result);
    serial_master master (.sclk, .cs_n, .din, .dout);
    always #12.5 sys_clk = !sys_clk;
    always @(posedge sys_clk) if (++cycles == 5000) finish_test();
    task automatic check(string what, logic [15:0] seen, exp);
        checks++;
        errors += (seen !== exp);
        if (seen !== exp) $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    endtask
    task automatic finish_test();
        errors += (cycles >= 5000);
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic xfer(int n, logic [15:0] tx, logic sel, int gap);
        master.frame(n, tx, sel, rx);
        repeat (gap) @(posedge sys_clk);
        #1;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        check("result", temp_result, 16'h0000);
        foreach (rows[r]) begin
            adc_sample = rows[r][28:16];
            xfer(16, 16'h0000, 1'b1, 40);
            xfer(16, 16'h0000, 1'b1, 40);
            check("frame", rx, rows[r][15:0]);
            check("result", temp_result, rows[r][28:16]);
        end
        xfer(16, 16'h2000, 1'b1, 40);
        check("shutdown", shutdown, 16'h0001);
        adc_sample = 13'h0aaa;
        xfer(16, 16'h0000, 1'b0, 400);
        xfer(14, 16'h0000, 1'b1, 40);
        check("shutdown", shutdown, 16'h0001);
        check("held", rx[15:2], 16'h0960);
        xfer(16, 16'h0000, 1'b1, 40);
        check("result", temp_result, 16'h0aaa);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
